// [logic/acq_timing_pkg.sv]
// constants, register map and types for the acquisition trigger timing block
package acq_timing_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int GP_NUM = 3;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SCAN_LOW_NS = 1000;
  localparam int LATCH_NS = 90;
  localparam logic [15:0] SCAN_LOW_CYC = 16'(SCAN_LOW_NS / CLK_PERIOD_NS);
  localparam int LATCH_CNT_W = 5;
  localparam logic [LATCH_CNT_W-1:0] LATCH_CYC = LATCH_CNT_W'((LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STROBE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_INTERVAL = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_REMAIN = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_TIMEBASE = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_DIVIDED_FREQUENCY_OUT = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_GP_BASE = 8'h10;
  localparam int GP_STRIDE = 4;
  localparam int GP_CFG_OFF = 0;
  localparam int GP_LIMIT_OFF = 1;
  localparam int GP_COUNT_OFF = 2;

  localparam int CTRL_SCAN_EN = 0;
  localparam int CTRL_PACE_EXT = 1;
  localparam int CTRL_PRETRIG = 2;
  localparam int CTRL_ARM = 3;
  localparam int CTRL_ABORT = 4;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0002;

  localparam int STAT_ARMED = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_STOP_SEEN = 2;
  localparam int STAT_DONE = 3;

  localparam int GP_EN = 0;
  localparam int GP_SRC_EXT = 1;
  localparam int GP_FALL = 2;
  localparam int GP_GMODE_LSB = 3;
  localparam int GP_GPOL = 5;
  localparam int GP_TOGGLE = 6;
  localparam int GP_CFG_W = 7;

  localparam logic [DATA_W-1:0] INTERVAL_RST = 16'h0200;
  localparam logic [DATA_W-1:0] COUNT_RST = 16'h0010;
  localparam logic [DATA_W-1:0] DIV_RST = 16'h0000;
  localparam logic [DATA_W-1:0] GP_LIMIT_RST = 16'hffff;

  localparam int TRIG_CONV = 0;
  localparam int TRIG_START = 1;
  localparam int TRIG_STOP = 2;
  localparam logic [2:0] TRIG_IDLE = 3'h3;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_ARMED = 2'b01,
    ACQ_RUN = 2'b10
  } acq_state_e;

  typedef enum logic [1:0] {
    GATE_NONE = 2'b00,
    GATE_LEVEL = 2'b01,
    GATE_EDGE = 2'b10
  } gate_mode_e;
endpackage

// [logic/acquisition_trigger_timing.sv]
// acquisition trigger, scan/strobe pulse and general counter timing logic
// Behaviour
// - scan output idles high, low ~1us before conversion under internal pacing, for the external trigger low time otherwise
// - scan pulses only while scanning is enabled
// - strobe register write gives one low latch pulse
// - latch pulse about 90ns, never under 65ns
// - conversion starts on trigger rising edge
// - conversion begins within 100ns of rising edge
// - interval counter drives shared trigger line or floats
// - armed counters start on start input falling edge
// - start input ignored under external conversion pacing
// - first conversion one interval plus synchroniser and launch cycles after start
// - pretrigger: sample counting waits for stop rising edge
// - general counter pulses or toggles at terminal count
// - general counter counts chosen edge, value readable
// - level gating counts only at programmed gate level
// - edge gating starts counting after programmed gate edge
`timescale 1ns/1ns
module acquisition_trigger_timing
  import acq_timing_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_conversion_trigger_n,
  output logic o_conversion_trigger_n,
  output logic o_conversion_trigger_oe,
  input wire logic i_acquisition_start_n,
  input wire logic i_pretrigger_stop,
  output logic o_scan_step_pulse,
  output logic o_user_latch_pulse_n,
  output logic o_convert_start,
  input wire logic [GP_NUM-1:0] i_gp_source,
  input wire logic [GP_NUM-1:0] i_gp_gate,
  output logic [GP_NUM-1:0] o_gp_out,
  output logic o_divided_frequency_out
);

  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic fell(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction

  function automatic logic [ADDR_W-1:0] gp_addr(input int n, input int off);
    return ADDR_GP_BASE + ADDR_W'(n * GP_STRIDE + off);
  endfunction

  // trigger synchronisers: meta stage is read only by the sync stage
  logic [2:0] trig_meta;
  logic [2:0] trig_sync;
  logic [2:0] trig_prev;
  wire [2:0] trig_pins = {i_pretrigger_stop, i_acquisition_start_n, i_conversion_trigger_n};

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      trig_meta <= TRIG_IDLE;
      trig_sync <= TRIG_IDLE;
      trig_prev <= TRIG_IDLE;
    end
    else
    begin
      trig_meta <= trig_pins;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  // the trigger line is watched whoever drives it, so both pacing modes share one path
  wire conv_rise = rose(trig_sync[TRIG_CONV], trig_prev[TRIG_CONV]);
  wire conv_fall = fell(trig_sync[TRIG_CONV], trig_prev[TRIG_CONV]);
  wire start_fall = fell(trig_sync[TRIG_START], trig_prev[TRIG_START]);
  wire stop_rise = rose(trig_sync[TRIG_STOP], trig_prev[TRIG_STOP]);

  // register decode
  wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
  wire wr_strobe = i_wr && (i_addr == ADDR_STROBE);
  wire wr_interval = i_wr && (i_addr == ADDR_INTERVAL);
  wire wr_count = i_wr && (i_addr == ADDR_COUNT);
  wire wr_timebase = i_wr && (i_addr == ADDR_TIMEBASE);
  wire wr_divided_frequency_out = i_wr && (i_addr == ADDR_DIVIDED_FREQUENCY_OUT);
  wire arm_req = wr_ctrl && i_wdata[CTRL_ARM];
  wire abort_req = wr_ctrl && i_wdata[CTRL_ABORT];

  logic scan_en;
  logic pace_ext;
  logic pretrig;
  logic [DATA_W-1:0] interval_reload;
  logic [DATA_W-1:0] count_load;
  logic [DATA_W-1:0] timebase_div;
  logic [DATA_W-1:0] divided_frequency_out_div;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      scan_en <= CTRL_RST[CTRL_SCAN_EN];
      pace_ext <= CTRL_RST[CTRL_PACE_EXT];
      pretrig <= CTRL_RST[CTRL_PRETRIG];
      interval_reload <= INTERVAL_RST;
      count_load <= COUNT_RST;
      timebase_div <= DIV_RST;
      divided_frequency_out_div <= DIV_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        scan_en <= i_wdata[CTRL_SCAN_EN];
        pace_ext <= i_wdata[CTRL_PACE_EXT];
        pretrig <= i_wdata[CTRL_PRETRIG];
      end
      if (wr_interval)
        interval_reload <= i_wdata;
      if (wr_count)
        count_load <= i_wdata;
      if (wr_timebase)
        timebase_div <= i_wdata;
      if (wr_divided_frequency_out)
        divided_frequency_out_div <= i_wdata;
    end
  end

  // acquisition sequencing
  acq_state_e state;
  acq_state_e next_state;
  logic [DATA_W-1:0] sample_remain;
  logic [DATA_W-1:0] interval_cnt;
  logic stop_seen;
  logic done;

  wire run = (state == ACQ_RUN);
  wire count_en = run && (!pretrig || stop_seen);
  wire finish = run && (sample_remain == '0);
  wire launch = (state == ACQ_ARMED) && (next_state == ACQ_RUN);
  wire pace_run = run && !pace_ext;
  wire pace_low = pace_run && (interval_cnt <= SCAN_LOW_CYC);

  always_comb
  begin
    next_state = state;
    case (state)
      ACQ_IDLE:
        if (arm_req)
          next_state = ACQ_ARMED;
      ACQ_ARMED:
        if (abort_req)
          next_state = ACQ_IDLE;
        else if (pace_ext || start_fall)
          next_state = ACQ_RUN;
      ACQ_RUN:
        if (abort_req || finish)
          next_state = ACQ_IDLE;
      default:
        next_state = ACQ_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      state <= ACQ_IDLE;
      sample_remain <= '0;
      stop_seen <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if ((state == ACQ_IDLE) && arm_req)
        sample_remain <= count_load;
      else if (conv_rise && count_en && (sample_remain != '0))
        sample_remain <= sample_remain - 16'h0001;
      if ((state == ACQ_IDLE) && arm_req)
        stop_seen <= 1'b0;
      else if (run && stop_rise)
        stop_seen <= 1'b1;
      // a finish in the same cycle as a new arm keeps the flag set
      done <= finish || (done && !arm_req);
    end
  end

  // sample-interval counter: reloads at 1, drives the line low for the last scan window
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      interval_cnt <= '0;
    else if (launch)
      interval_cnt <= interval_reload;
    else if (pace_run)
      interval_cnt <= (interval_cnt <= 16'h0001) ? interval_reload : interval_cnt - 16'h0001;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_conversion_trigger_n <= 1'b1;
      o_conversion_trigger_oe <= 1'b0;
    end
    else
    begin
      o_conversion_trigger_n <= !pace_low;
      // floating under external pacing, so an outside source can own the line
      o_conversion_trigger_oe <= !pace_ext;
    end
  end

  // scan pulse follows the line low time; under internal pacing that is exactly the 1us window
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_scan_step_pulse <= 1'b1;
      o_convert_start <= 1'b0;
    end
    else
    begin
      o_convert_start <= run && conv_rise;
      if (!scan_en || !run)
        o_scan_step_pulse <= 1'b1;
      else if (conv_fall)
        o_scan_step_pulse <= 1'b0;
      else if (conv_rise)
        o_scan_step_pulse <= 1'b1;
    end
  end

  // user latch strobe
  logic [LATCH_CNT_W-1:0] latch_cnt;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      latch_cnt <= '0;
      o_user_latch_pulse_n <= 1'b1;
    end
    else if (wr_strobe)
    begin
      // a write during a pulse restarts it rather than dropping it
      latch_cnt <= LATCH_CYC - 5'h01;
      o_user_latch_pulse_n <= 1'b0;
    end
    else if (latch_cnt != '0)
      latch_cnt <= latch_cnt - 5'h01;
    else
      o_user_latch_pulse_n <= 1'b1;
  end

  // internal timebase and divided frequency output
  logic [DATA_W-1:0] tb_cnt;
  logic [DATA_W-1:0] divided_frequency_out_cnt;
  wire tb_tick = (tb_cnt == '0);

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      tb_cnt <= '0;
      divided_frequency_out_cnt <= '0;
      o_divided_frequency_out <= 1'b0;
    end
    else
    begin
      tb_cnt <= tb_tick ? timebase_div : tb_cnt - 16'h0001;
      divided_frequency_out_cnt <= (divided_frequency_out_cnt == '0) ? divided_frequency_out_div : divided_frequency_out_cnt - 16'h0001;
      if (divided_frequency_out_cnt == '0)
        o_divided_frequency_out <= !o_divided_frequency_out;
    end
  end

  // general-purpose counters
  logic [GP_CFG_W-1:0] gp_cfg [GP_NUM];
  logic [DATA_W-1:0] gp_limit [GP_NUM];
  logic [DATA_W-1:0] gp_count [GP_NUM];
  logic [GP_NUM-1:0] gp_src_prev;
  logic [GP_NUM-1:0] gp_gate_prev;
  logic [GP_NUM-1:0] gp_started;
  logic [GP_NUM-1:0] gp_step;
  logic [GP_NUM-1:0] gp_tc;
  logic [GP_NUM-1:0] gp_gate_edge;

  always_comb
  begin
    gp_step = '0;
    gp_tc = '0;
    gp_gate_edge = '0;
    for (int n = 0; n < GP_NUM; n++)
    begin
      logic ev;
      logic gate_ok;
      ev = 1'b0;
      gate_ok = 1'b0;
      if (gp_cfg[n][GP_SRC_EXT])
        ev = gp_cfg[n][GP_FALL] ? fell(i_gp_source[n], gp_src_prev[n])
                                : rose(i_gp_source[n], gp_src_prev[n]);
      else
        ev = tb_tick;
      gp_gate_edge[n] = gp_cfg[n][GP_GPOL] ? rose(i_gp_gate[n], gp_gate_prev[n])
                                          : fell(i_gp_gate[n], gp_gate_prev[n]);
      case (gate_mode_e'(gp_cfg[n][GP_GMODE_LSB +: 2]))
        GATE_NONE: gate_ok = 1'b1;
        GATE_LEVEL: gate_ok = (i_gp_gate[n] == gp_cfg[n][GP_GPOL]);
        GATE_EDGE: gate_ok = gp_started[n];
        default: gate_ok = 1'b0;
      endcase
      gp_step[n] = gp_cfg[n][GP_EN] && ev && gate_ok;
      gp_tc[n] = gp_step[n] && (gp_count[n] == gp_limit[n]);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      gp_src_prev <= '0;
      gp_gate_prev <= '0;
      gp_started <= '0;
      o_gp_out <= '0;
      for (int n = 0; n < GP_NUM; n++)
      begin
        gp_cfg[n] <= '0;
        gp_limit[n] <= GP_LIMIT_RST;
        gp_count[n] <= '0;
      end
    end
    else
    begin
      gp_src_prev <= i_gp_source;
      gp_gate_prev <= i_gp_gate;
      for (int n = 0; n < GP_NUM; n++)
      begin
        if (i_wr && (i_addr == gp_addr(n, GP_CFG_OFF)))
        begin
          gp_cfg[n] <= i_wdata[GP_CFG_W-1:0];
          gp_started[n] <= 1'b0;
        end
        else if (gp_cfg[n][GP_EN] && gp_gate_edge[n])
          gp_started[n] <= 1'b1;
        if (i_wr && (i_addr == gp_addr(n, GP_LIMIT_OFF)))
          gp_limit[n] <= i_wdata;
        if (i_wr && (i_addr == gp_addr(n, GP_COUNT_OFF)))
          gp_count[n] <= i_wdata;
        else if (gp_step[n])
          gp_count[n] <= gp_tc[n] ? '0 : gp_count[n] + 16'h0001;
        if (gp_cfg[n][GP_TOGGLE])
          o_gp_out[n] <= o_gp_out[n] ^ gp_tc[n];
        else
          o_gp_out[n] <= gp_tc[n];
      end
    end
  end

  // read path: unmapped addresses read zero
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    case (i_addr)
      ADDR_CTRL: rd_mux = DATA_W'({pretrig, pace_ext, scan_en});
      ADDR_INTERVAL: rd_mux = interval_reload;
      ADDR_COUNT: rd_mux = count_load;
      ADDR_STATUS: rd_mux = DATA_W'({done, stop_seen, run, state == ACQ_ARMED});
      ADDR_REMAIN: rd_mux = sample_remain;
      ADDR_TIMEBASE: rd_mux = timebase_div;
      ADDR_DIVIDED_FREQUENCY_OUT: rd_mux = divided_frequency_out_div;
      default: rd_mux = '0;
    endcase
    for (int n = 0; n < GP_NUM; n++)
    begin
      if (i_addr == gp_addr(n, GP_CFG_OFF))
        rd_mux = DATA_W'(gp_cfg[n]);
      if (i_addr == gp_addr(n, GP_LIMIT_OFF))
        rd_mux = gp_limit[n];
      if (i_addr == gp_addr(n, GP_COUNT_OFF))
        rd_mux = gp_count[n];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      o_rdata <= '0;
    else
      o_rdata <= i_rd ? rd_mux : '0;
  end

endmodule

// [tb/acq_timing_properties.sv]
// concurrent checks on the acquisition trigger timing ports
`timescale 1ns/1ns
module acq_timing_properties
  import acq_timing_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_conversion_trigger_n,
  input wire logic o_conversion_trigger_n,
  input wire logic o_conversion_trigger_oe,
  input wire logic o_scan_step_pulse,
  input wire logic o_user_latch_pulse_n,
  input wire logic o_convert_start
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] lat_cnt;
  logic [8:0] pace_cnt;
  // run lengths go in counters, too long for a repetition
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      lat_cnt <= 8'h00;
      pace_cnt <= 9'h000;
    end
    else
    begin
      lat_cnt <= o_user_latch_pulse_n ? 8'h00 : lat_cnt + 8'h01;
      pace_cnt <= (o_conversion_trigger_oe && !o_conversion_trigger_n) ? pace_cnt + 9'h001 : 9'h000;
    end
  end
  a_strobe_launch: assert property (i_wr && i_addr == ADDR_STROBE |=> !o_user_latch_pulse_n)
    else $error("latch pulse did not follow strobe write");
  a_strobe_cause: assert property ($fell(o_user_latch_pulse_n) |-> $past(i_wr && i_addr == ADDR_STROBE))
    else $error("latch pulse without strobe write");
  // 17 to 23 cycles: at least 65 ns, about 90 ns
  a_latch_width: assert property ($rose(o_user_latch_pulse_n) |-> lat_cnt >= 8'h11 && lat_cnt <= 8'h17)
    else $error("latch pulse width out of range");
  // scan edge and conversion pulse leave the same clock edge
  a_scan_to_conv: assert property ($rose(o_scan_step_pulse) |-> o_convert_start)
    else $error("scan rising edge without conversion");
  a_scan_min_low: assert property ($fell(o_scan_step_pulse) |-> !o_scan_step_pulse [*8])
    else $error("scan low window too short");
  a_conv_after_rise: assert property (o_convert_start |-> i_conversion_trigger_n && !$past(i_conversion_trigger_n, 8))
    else $error("conversion not tied to recent trigger rise");
  a_conv_single: assert property (o_convert_start |=> !o_convert_start)
    else $error("conversion start longer than one cycle");
  a_pace_low_len: assert property ($rose(o_conversion_trigger_n) && o_conversion_trigger_oe |-> pace_cnt == 9'h0fa)
    else $error("paced trigger low window not 250 cycles");
  c_latch: cover property ($rose(o_user_latch_pulse_n));
  c_paced_conv: cover property (o_convert_start && o_conversion_trigger_oe);
  c_scan: cover property ($fell(o_scan_step_pulse));
endmodule
bind acquisition_trigger_timing acq_timing_properties i_chk (
  .i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b),
  .i_addr(i_addr),
  .i_wr(i_wr),
  .i_conversion_trigger_n(i_conversion_trigger_n),
  .o_conversion_trigger_n(o_conversion_trigger_n),
  .o_conversion_trigger_oe(o_conversion_trigger_oe),
  .o_scan_step_pulse(o_scan_step_pulse),
  .o_user_latch_pulse_n(o_user_latch_pulse_n),
  .o_convert_start(o_convert_start)
);

// [tb/testbench.sv]
// self-checking testbench for the acquisition trigger timing block
`timescale 1ns/1ns
module testbench;
  import acq_timing_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic conv_wire, drv_n, drv_oe, src_n, start_n, stop, scan, latch_n, conv, divided_frequency_out;
  logic [GP_NUM-1:0] gp_src, gp_gate, gp_out;
  logic scan_low_seen = 1'b0;
  logic [GP_NUM-1:0] gp_hit = '0;
  int err_total = 0;
  int tests_run = 0;
  int conv_seen = 0;
  int cycles = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  // shared wire: our drive when enabled, else the source or its pull-up
  assign conv_wire = drv_oe ? drv_n : src_n;
  acquisition_trigger_timing i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_conversion_trigger_n(conv_wire), .o_conversion_trigger_n(drv_n),
    .o_conversion_trigger_oe(drv_oe), .i_acquisition_start_n(start_n), .i_pretrigger_stop(stop),
    .o_scan_step_pulse(scan), .o_user_latch_pulse_n(latch_n), .o_convert_start(conv), .i_gp_source(gp_src),
    .i_gp_gate(gp_gate), .o_gp_out(gp_out), .o_divided_frequency_out(divided_frequency_out));
  trigger_sources i_src (.i_ref_clk(i_ref_clk), .o_conv_n(src_n), .o_start_n(start_n), .o_stop(stop),
    .o_gp_source(gp_src), .o_gp_gate(gp_gate));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (conv === 1'b1)
      conv_seen++;
    if (scan === 1'b0)
      scan_low_seen = 1'b1;
    gp_hit = gp_hit | gp_out;
    if (cycles == 30000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    @(posedge i_ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_ref_clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask
  function automatic logic [ADDR_W-1:0] gpa(input int g, input int off);
    return ADDR_W'(int'(ADDR_GP_BASE) + GP_STRIDE * g + off);
  endfunction
  task automatic pulses(input int g, input int k);
    repeat (k) i_src.src_pulse(g);
  endtask
  initial
  begin
    int n;
    int c0;
    repeat (20) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd_reg(ADDR_CTRL, CTRL_RST, "ctrl");
    rd_reg(ADDR_INTERVAL, INTERVAL_RST, "interval");
    rd_reg(ADDR_COUNT, COUNT_RST, "count");
    rd_reg(8'h08, 16'h0000, "unmapped");
    chk("float", 16'(drv_oe), 16'h0000);
    $display("test registers done");
    wr_reg(ADDR_STROBE, 16'h0000);
    #1;
    n = 0;
    while (latch_n === 1'b0 && n < 40)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk("latch width", 16'(n), 16'h0017);
    $display("test strobe done");
    wr_reg(ADDR_COUNT, 16'h0002);
    wr_reg(ADDR_CTRL, 16'h000b);
    c0 = conv_seen;
    i_src.conv_pulse();
    chk("ext conv", 16'(conv_seen - c0), 16'h0001);
    chk("scan low", 16'(scan_low_seen), 16'h0001);
    rd_reg(ADDR_REMAIN, 16'h0001, "remain");
    i_src.conv_pulse();
    rd_reg(ADDR_STATUS, 16'h0008, "ext done");
    // second run without scanning: conversions go on, scan stays high
    scan_low_seen = 1'b0;
    wr_reg(ADDR_CTRL, 16'h000a);
    c0 = conv_seen;
    i_src.conv_pulse();
    chk("no scan", 16'(scan_low_seen), 16'h0000);
    chk("conv", 16'(conv_seen - c0), 16'h0001);
    wr_reg(ADDR_CTRL, 16'h0012);
    $display("test external pacing done");
    wr_reg(ADDR_COUNT, 16'h0001);
    wr_reg(ADDR_CTRL, 16'h000e);
    i_src.conv_pulse();
    i_src.conv_pulse();
    rd_reg(ADDR_REMAIN, 16'h0001, "pretrig hold");
    i_src.stop_rise();
    i_src.conv_pulse();
    rd_reg(ADDR_STATUS, 16'h000c, "pretrig done");
    $display("test pretrigger done");
    wr_reg(ADDR_INTERVAL, 16'h012c);
    wr_reg(ADDR_COUNT, 16'h0001);
    wr_reg(ADDR_CTRL, 16'h0009);
    c0 = conv_seen;
    repeat (400) @(posedge i_ref_clk);
    chk("armed wait", 16'(conv_seen - c0), 16'h0000);
    chk("drive", 16'(drv_oe), 16'h0001);
    i_src.start_fall();
    n = 40;
    while (conv_seen == c0 && n < 600)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    // one interval of 300 plus the synchroniser and launch cycles
    chk("first conv", 16'(n <= 312), 16'h0001);
    rd_reg(ADDR_STATUS, 16'h0008, "paced done");
    $display("test internal pacing done");
    wr_reg(gpa(0, GP_LIMIT_OFF), 16'h0002);
    wr_reg(gpa(0, GP_CFG_OFF), 16'h0003);
    pulses(0, 2);
    rd_reg(gpa(0, GP_COUNT_OFF), 16'h0002, "gp count");
    pulses(0, 1);
    rd_reg(gpa(0, GP_COUNT_OFF), 16'h0000, "gp wrap");
    chk("gp pulse", 16'(gp_hit[0]), 16'h0001);
    wr_reg(gpa(0, GP_CFG_OFF), 16'h0043);
    pulses(0, 3);
    chk("gp toggle", 16'(gp_out[0]), 16'h0001);
    // falling edges only: counting rising ones too would wrap to 1
    wr_reg(gpa(0, GP_CFG_OFF), 16'h0007);
    pulses(0, 2);
    rd_reg(gpa(0, GP_COUNT_OFF), 16'h0002, "gp falling");
    wr_reg(gpa(1, GP_CFG_OFF), 16'h002b);
    pulses(1, 2);
    rd_reg(gpa(1, GP_COUNT_OFF), 16'h0000, "gate shut");
    i_src.set_gate(1, 1'b1);
    pulses(1, 2);
    rd_reg(gpa(1, GP_COUNT_OFF), 16'h0002, "gate open");
    wr_reg(gpa(2, GP_CFG_OFF), 16'h0033);
    pulses(2, 2);
    rd_reg(gpa(2, GP_COUNT_OFF), 16'h0000, "edge wait");
    i_src.set_gate(2, 1'b1);
    pulses(2, 2);
    rd_reg(gpa(2, GP_COUNT_OFF), 16'h0002, "edge start");
    // divider of 3 toggles every 4 clocks; skip the toggles left from the old setting
    wr_reg(ADDR_DIVIDED_FREQUENCY_OUT, 16'h0003);
    repeat (2) @(posedge i_ref_clk);
    @(divided_frequency_out);
    n = cycles;
    @(divided_frequency_out);
    chk("divided_frequency_out period", 16'(cycles - n), 16'h0004);
    $display("test counters done");
    report_and_stop();
  end
endmodule

// [tb/trigger_sources.sv]
// model of the external trigger sources and counter inputs
`timescale 1ns/1ns
module trigger_sources
  import acq_timing_pkg::*;
(
  input wire logic i_ref_clk,
  output logic o_conv_n,
  output logic o_start_n,
  output logic o_stop,
  output logic [GP_NUM-1:0] o_gp_source,
  output logic [GP_NUM-1:0] o_gp_gate
);
  // 20 cycles is 80 ns, above the 50 ns minimum for every trigger level; counter source levels last 4 cycles
  localparam int HOLD = 20;
  initial
  begin
    o_conv_n = 1'b1;
    o_start_n = 1'b1;
    o_stop = 1'b0;
    o_gp_source = '0;
    o_gp_gate = '0;
  end
  // released trigger wire reads high through its pull-up
  task automatic conv_pulse();
    @(posedge i_ref_clk);
    o_conv_n <= 1'b0;
    repeat (HOLD) @(posedge i_ref_clk);
    o_conv_n <= 1'b1;
    repeat (HOLD) @(posedge i_ref_clk);
  endtask
  task automatic start_fall();
    @(posedge i_ref_clk);
    o_start_n <= 1'b0;
    repeat (HOLD) @(posedge i_ref_clk);
    o_start_n <= 1'b1;
    repeat (HOLD) @(posedge i_ref_clk);
  endtask
  task automatic stop_rise();
    @(posedge i_ref_clk);
    o_stop <= 1'b1;
    repeat (HOLD) @(posedge i_ref_clk);
    o_stop <= 1'b0;
    repeat (HOLD) @(posedge i_ref_clk);
  endtask
  task automatic src_pulse(input int g);
    @(posedge i_ref_clk);
    o_gp_source[g] <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    o_gp_source[g] <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  task automatic set_gate(input int g, input logic v);
    @(posedge i_ref_clk);
    o_gp_gate[g] <= v;
  endtask
endmodule
